// >>> rtl/fsps_axil_slave.v
/*
  AXI4-Lite slave front end: one write and one read at a time.
  Assumes the owner decodes addresses combinationally.
*/
`timescale 1ns/1ps

module fsps_axil_slave (
  input wire ref_clk,
  input wire reset_n,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg regWrEn,
  output reg [7:0] regWrAddr,
  output reg [7:0] regWrData,
  output reg regWrLane,
  input wire wrHit,
  input wire [7:0] rdAddr,
  input wire [31:0] rdData,
  input wire rdHit
);

  reg awHeld_q;
  reg wHeld_q;
  wire awTake = s_axi_awvalid && s_axi_awready;
  wire wTake = s_axi_wvalid && s_axi_wready;
  wire arTake = s_axi_arvalid && s_axi_arready;

  // ----------------------------------------
  // write path: address and data in any order
  // ----------------------------------------
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      regWrEn <= 1'b0;
      regWrAddr <= 8'h00;
      regWrData <= 8'h00;
      regWrLane <= 1'b0;
    end else begin
      regWrEn <= 1'b0;
      s_axi_awready <= !awHeld_q && !awTake && !s_axi_bvalid;
      s_axi_wready <= !wHeld_q && !wTake && !s_axi_bvalid;
      if (awTake) begin
        awHeld_q <= 1'b1;
        regWrAddr <= s_axi_awaddr;
      end
      if (wTake) begin
        wHeld_q <= 1'b1;
        regWrData <= s_axi_wdata[7:0];
        regWrLane <= s_axi_wstrb[0];
      end
      // both halves held: one strobe, then the response
      if (awHeld_q && wHeld_q && !s_axi_bvalid && !regWrEn) begin
        regWrEn <= 1'b1;
      end
      if (regWrEn) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrHit ? 2'h0 : 2'h2;
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // read path: data captured at the address edge
  // ----------------------------------------
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !arTake;
      if (arTake) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdHit ? rdData : 32'h00000000;
        s_axi_rresp <= rdHit ? 2'h0 : 2'h2;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // fsps_axil_slave

// >>> rtl/fsps_defines.vh
/*
  Constants for the flash self-program sequencer.
  Assumes a 200 MHz ref_clk and a 32-bit AXI4-Lite register bus.
*/
// How it works
// - erase program memory only by whole rows
// - key 55h then AAh before launch
// - row-erase bit clears when erase ends
// - two setup cycles follow the launch
// - stall core about 2 ms per erase
// - core resumes third instruction after launch
// - programming never erases; software pre-erases
// - block aligned by low address, no crossing
// - latches reset to 0x3FFF after programming
// - latch-only launch just loads one latch
// - normal launch loads last, programs block
// - whole latch block always programmed
`ifndef FSPS_DEFINES_VH
`define FSPS_DEFINES_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define FSPS_OFF_ADDR_LOW 8'h00
`define FSPS_OFF_ADDR_HIGH 8'h04
`define FSPS_OFF_DATA_LOW 8'h08
`define FSPS_OFF_DATA_HIGH 8'h0C
`define FSPS_OFF_CONTROL 8'h10
`define FSPS_OFF_UNLOCK 8'h14

// ----------------------------------------
// control register fields
// ----------------------------------------
`define FSPS_BIT_LAUNCH 0
`define FSPS_BIT_PROG_EN 1
`define FSPS_BIT_ROW_ERASE 2
`define FSPS_BIT_LATCH_ONLY 3
`define FSPS_BIT_CFG_SPACE 6
`define FSPS_BIT_PGM_SPACE 7

// ----------------------------------------
// keys, reset values, timing
// ----------------------------------------
`define FSPS_KEY_FIRST 8'h55
`define FSPS_KEY_SECOND 8'hAA
`define FSPS_LATCH_RESET 14'h3FFF
`define FSPS_LATCH_COUNT 32
`define FSPS_SETUP_CYCLES 2
`define FSPS_CLK_MHZ 200
`define FSPS_ERASE_TIME_MS 2
`define FSPS_PROG_TIME_MS 2

`endif

// >>> rtl/fsps_latch_bank.v
/*
  Write latch bank: one 14-bit word per latch, flip-flop storage.
  Assumes load and clear come from the sequencer on the same clock.
*/
`timescale 1ns/1ps
`include "fsps_defines.vh"

module fsps_latch_bank #(
  parameter COUNT = `FSPS_LATCH_COUNT,
  parameter IDX_W = 5
) (
  input wire ref_clk,
  input wire reset_n,
  input wire loadEn,
  input wire [IDX_W-1:0] loadIdx,
  input wire [13:0] loadData,
  input wire clearAll,
  input wire [IDX_W-1:0] rdIdx,
  output wire [13:0] rdWord
);

  wire [14*COUNT-1:0] flat;

  // ----------------------------------------
  // one latch per entry
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < COUNT; i = i + 1) begin : gLatch
      reg [13:0] word_q;
      // clear wins: a finished block leaves every latch erased-state
      always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
          word_q <= `FSPS_LATCH_RESET;
        end else if (clearAll) begin
          word_q <= `FSPS_LATCH_RESET;
        end else if (loadEn && loadIdx == i) begin
          word_q <= loadData;
        end
      end
      assign flat[14*i +: 14] = word_q;
    end
  endgenerate

  assign rdWord = flat[14*rdIdx +: 14];

endmodule // fsps_latch_bank

// >>> rtl/fsps_sequencer.v
/*
  Flash self-program sequencer: registers, unlock, erase and block write.
  Assumes the core honours coreStall and the array takes one word a cycle.
*/
// The AXI4-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "fsps_defines.vh"

module fsps_sequencer #(
  parameter LATCH_COUNT = `FSPS_LATCH_COUNT,
  parameter IDX_W = 5,
  parameter [31:0] ERASE_CYCLES = `FSPS_ERASE_TIME_MS * `FSPS_CLK_MHZ * 1000,
  parameter [31:0] PROG_CYCLES = `FSPS_PROG_TIME_MS * `FSPS_CLK_MHZ * 1000
) (
  input wire ref_clk,
  input wire reset_n,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  output reg coreStall,
  output reg flashEraseEn,
  output reg flashWrEn,
  output reg [15:0] flashAddr,
  output reg [13:0] flashData
);

  // ----------------------------------------
  // state codes
  // ----------------------------------------
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_SETUP = 3'd1;
  localparam [2:0] ST_ERASE = 3'd2;
  localparam [2:0] ST_STREAM = 3'd3;
  localparam [2:0] ST_PROGWAIT = 3'd4;

  localparam [1:0] KEY_NONE = 2'd0;
  localparam [1:0] KEY_HALF = 2'd1;
  localparam [1:0] KEY_ARMED = 2'd2;

  localparam [31:0] SETUP_LAST = `FSPS_SETUP_CYCLES - 1;
  localparam [31:0] IDX_LAST_W = LATCH_COUNT - 1;
  localparam [IDX_W-1:0] IDX_LAST = IDX_LAST_W[IDX_W-1:0];

  // ----------------------------------------
  // bus front end
  // ----------------------------------------
  wire regWrEn;
  wire [7:0] regWrAddr;
  wire [7:0] regWrData;
  wire regWrLane;
  reg wrHit;
  reg rdHit;
  reg [31:0] rdData;

  fsps_axil_slave uBus (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .regWrEn(regWrEn),
    .regWrAddr(regWrAddr),
    .regWrData(regWrData),
    .regWrLane(regWrLane),
    .wrHit(wrHit),
    .rdAddr(s_axi_araddr),
    .rdData(rdData),
    .rdHit(rdHit)
  );

  // ----------------------------------------
  // software-visible registers
  // ----------------------------------------
  reg [7:0] nvmAddrLow_q;
  reg [7:0] nvmAddrHigh_q;
  reg [7:0] nvmDataLow_q;
  reg [5:0] nvmDataHigh_q;
  reg launch_q;
  reg programEnable_q;
  reg rowErase_q;
  reg latchOnlyLoad_q;
  reg configSpaceSelect_q;
  reg programSpaceSelect_q;
  reg [1:0] keyState_q;

  reg [2:0] state_q;
  reg [31:0] timer_q;
  reg [IDX_W-1:0] streamIdx_q;
  reg opErase_q;
  reg opLatchOnly_q;
  reg latchLoad;
  reg latchClear;

  wire ctrlWrite = regWrEn && regWrLane && regWrAddr == `FSPS_OFF_CONTROL;
  wire keyWrite = regWrEn && regWrLane && regWrAddr == `FSPS_OFF_UNLOCK;
  wire wantLaunch = ctrlWrite && regWrData[`FSPS_BIT_LAUNCH];
  wire [15:0] fullAddr = {nvmAddrHigh_q, nvmAddrLow_q};
  wire [13:0] fullData = {nvmDataHigh_q, nvmDataLow_q};
  // block base: low index bits cleared, so a block never crosses
  wire [15:0] blockBase = {fullAddr[15:IDX_W], {IDX_W{1'b0}}};
  wire [IDX_W-1:0] latchIdx = nvmAddrLow_q[IDX_W-1:0];
  wire [13:0] latchWord;

  // honoured only straight after both keys, with enable and
  // program space chosen; config space is not served here
  wire launchOk = wantLaunch && keyState_q == KEY_ARMED && state_q == ST_IDLE
    && regWrData[`FSPS_BIT_PROG_EN] && regWrData[`FSPS_BIT_PGM_SPACE]
    && !regWrData[`FSPS_BIT_CFG_SPACE];

  // ----------------------------------------
  // address decode for the slave
  // ----------------------------------------
  always @* begin
    case (regWrAddr)
      `FSPS_OFF_ADDR_LOW, `FSPS_OFF_ADDR_HIGH, `FSPS_OFF_DATA_LOW,
      `FSPS_OFF_DATA_HIGH, `FSPS_OFF_CONTROL, `FSPS_OFF_UNLOCK: wrHit = 1'b1;
      default: wrHit = 1'b0;
    endcase
  end

  // read mux; the key register reads as zero
  always @* begin
    rdHit = 1'b1;
    rdData = 32'h00000000;
    case (s_axi_araddr)
      `FSPS_OFF_ADDR_LOW: rdData[7:0] = nvmAddrLow_q;
      `FSPS_OFF_ADDR_HIGH: rdData[7:0] = nvmAddrHigh_q;
      `FSPS_OFF_DATA_LOW: rdData[7:0] = nvmDataLow_q;
      `FSPS_OFF_DATA_HIGH: rdData[5:0] = nvmDataHigh_q;
      `FSPS_OFF_CONTROL: begin
        rdData[`FSPS_BIT_LAUNCH] = launch_q;
        rdData[`FSPS_BIT_PROG_EN] = programEnable_q;
        rdData[`FSPS_BIT_ROW_ERASE] = rowErase_q;
        rdData[`FSPS_BIT_LATCH_ONLY] = latchOnlyLoad_q;
        rdData[`FSPS_BIT_CFG_SPACE] = configSpaceSelect_q;
        rdData[`FSPS_BIT_PGM_SPACE] = programSpaceSelect_q;
      end
      `FSPS_OFF_UNLOCK: rdData = 32'h00000000;
      default: rdHit = 1'b0;
    endcase
  end

  // ----------------------------------------
  // unlock key tracker
  // ----------------------------------------
  // any other write in between breaks the sequence
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      keyState_q <= KEY_NONE;
    end else if (keyWrite) begin
      if (regWrData == `FSPS_KEY_FIRST) begin
        keyState_q <= KEY_HALF;
      end else if (regWrData == `FSPS_KEY_SECOND && keyState_q == KEY_HALF) begin
        keyState_q <= KEY_ARMED;
      end else begin
        keyState_q <= KEY_NONE;
      end
    end else if (regWrEn) begin
      keyState_q <= KEY_NONE;
    end
  end

  // ----------------------------------------
  // address, data and control registers
  // ----------------------------------------
  // writes to address and data are dropped while busy
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      nvmAddrLow_q <= 8'h00;
      nvmAddrHigh_q <= 8'h00;
      nvmDataLow_q <= 8'h00;
      nvmDataHigh_q <= 6'h00;
      programEnable_q <= 1'b0;
      rowErase_q <= 1'b0;
      latchOnlyLoad_q <= 1'b0;
      configSpaceSelect_q <= 1'b0;
      programSpaceSelect_q <= 1'b0;
    end else begin
      if (regWrEn && regWrLane && state_q == ST_IDLE) begin
        case (regWrAddr)
          `FSPS_OFF_ADDR_LOW: nvmAddrLow_q <= regWrData;
          `FSPS_OFF_ADDR_HIGH: nvmAddrHigh_q <= regWrData;
          `FSPS_OFF_DATA_LOW: nvmDataLow_q <= regWrData;
          `FSPS_OFF_DATA_HIGH: nvmDataHigh_q <= regWrData[5:0];
          `FSPS_OFF_CONTROL: begin
            programEnable_q <= regWrData[`FSPS_BIT_PROG_EN];
            rowErase_q <= regWrData[`FSPS_BIT_ROW_ERASE];
            latchOnlyLoad_q <= regWrData[`FSPS_BIT_LATCH_ONLY];
            configSpaceSelect_q <= regWrData[`FSPS_BIT_CFG_SPACE];
            programSpaceSelect_q <= regWrData[`FSPS_BIT_PGM_SPACE];
          end
          default: ;
        endcase
      end
      // erase done: software polls this bit falling
      if (state_q == ST_ERASE && timer_q == ERASE_CYCLES - 1) begin
        rowErase_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // write latches
  // ----------------------------------------
  fsps_latch_bank #(
    .COUNT(LATCH_COUNT),
    .IDX_W(IDX_W)
  ) uLatch (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .loadEn(latchLoad),
    .loadIdx(latchIdx),
    .loadData(fullData),
    .clearAll(latchClear),
    .rdIdx(streamIdx_q),
    .rdWord(latchWord)
  );

  // latch load at the end of setup, clear after programming
  always @* begin
    latchLoad = 1'b0;
    latchClear = 1'b0;
    if (state_q == ST_SETUP && timer_q == SETUP_LAST && !opErase_q) begin
      latchLoad = 1'b1;
    end
    if (state_q == ST_PROGWAIT && timer_q == PROG_CYCLES - 1) begin
      latchClear = 1'b1;
    end
  end

  // ----------------------------------------
  // operation sequencer
  // ----------------------------------------
  // the core runs its two setup slots unstalled, then halts
  // until the array work ends; clocks never stop here
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      timer_q <= 32'h00000000;
      streamIdx_q <= {IDX_W{1'b0}};
      opErase_q <= 1'b0;
      opLatchOnly_q <= 1'b0;
      launch_q <= 1'b0;
      coreStall <= 1'b0;
      flashEraseEn <= 1'b0;
      flashWrEn <= 1'b0;
      flashAddr <= 16'h0000;
      flashData <= 14'h0000;
    end else begin
      flashEraseEn <= 1'b0;
      flashWrEn <= 1'b0;
      timer_q <= timer_q + 32'h00000001;
      case (state_q)
        ST_IDLE: begin
          timer_q <= 32'h00000000;
          if (launchOk) begin
            launch_q <= 1'b1;
            // erase takes priority over a latch write
            opErase_q <= regWrData[`FSPS_BIT_ROW_ERASE];
            opLatchOnly_q <= regWrData[`FSPS_BIT_LATCH_ONLY];
            state_q <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          if (timer_q == SETUP_LAST) begin
            timer_q <= 32'h00000000;
            streamIdx_q <= {IDX_W{1'b0}};
            if (opErase_q) begin
              // whole row only, addressed by its base
              flashEraseEn <= 1'b1;
              flashAddr <= blockBase;
              coreStall <= 1'b1;
              state_q <= ST_ERASE;
            end else if (opLatchOnly_q) begin
              launch_q <= 1'b0;
              state_q <= ST_IDLE;
            end else begin
              // no erase step precedes programming
              coreStall <= 1'b1;
              state_q <= ST_STREAM;
            end
          end
        end
        ST_ERASE: begin
          if (timer_q == ERASE_CYCLES - 1) begin
            coreStall <= 1'b0;
            launch_q <= 1'b0;
            state_q <= ST_IDLE;
          end
        end
        ST_STREAM: begin
          // every latch goes out, loaded this time or not
          flashWrEn <= 1'b1;
          flashAddr <= blockBase | {{(16 - IDX_W){1'b0}}, streamIdx_q};
          flashData <= latchWord;
          streamIdx_q <= streamIdx_q + {{(IDX_W - 1){1'b0}}, 1'b1};
          timer_q <= 32'h00000000;
          if (streamIdx_q == IDX_LAST) begin
            state_q <= ST_PROGWAIT;
          end
        end
        ST_PROGWAIT: begin
          if (timer_q == PROG_CYCLES - 1) begin
            coreStall <= 1'b0;
            launch_q <= 1'b0;
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          coreStall <= 1'b0;
          launch_q <= 1'b0;
        end
      endcase
    end
  end

endmodule // fsps_sequencer

// >>> tb/fsps_flash_model.sv
/*
  Behavioural program memory array behind the sequencer.
  Assumes one word per cycle and 128 words cover the rows used.
*/
`timescale 1ns/1ps

module fsps_flash_model (
  input wire ref_clk,
  input wire flashEraseEn,
  input wire flashWrEn,
  input wire [15:0] flashAddr,
  input wire [13:0] flashData
);
  reg [13:0] mem [0:127];
  integer j;

  // zero start so that erased and latch-reset words stand out
  initial begin
    for (j = 0; j < 128; j = j + 1) mem[j] = 14'h0000;
  end

  // erase clears a whole row only, write stores one word
  always @(posedge ref_clk) begin
    if (flashEraseEn) begin
      for (j = 0; j < 32; j = j + 1) mem[{flashAddr[6:5], j[4:0]}] <= 14'h3FFF;
    end
    if (flashWrEn) mem[flashAddr[6:0]] <= flashData;
  end
endmodule // fsps_flash_model

// >>> tb/fsps_sequencer_assertions.sv
/*
  Checker for the flash self-program sequencer top ports.
  Assumes binding to fsps_sequencer with short cycle counts.
*/
`timescale 1ns/1ps

module fsps_seq_assertions (
  input wire ref_clk,
  input wire reset_n,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire coreStall,
  input wire flashEraseEn,
  input wire flashWrEn,
  input wire [15:0] flashAddr
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // ----------------------------------------
  // sequences
  // ----------------------------------------
  // burst starts on a row base and ends on its last word
  sequence wrBurstStart;
    $rose(flashWrEn) && flashAddr[4:0] == 5'h00;
  endsequence
  sequence wrBurstEnd;
    flashWrEn && flashAddr[4:0] == 5'h1F ##1 !flashWrEn;
  endsequence

  // ----------------------------------------
  // properties
  // ----------------------------------------
  a_erase_pulse: assert property (flashEraseEn |=> !flashEraseEn [*8]) else $error("erase not a lone pulse");
  a_erase_row: assert property (flashEraseEn |-> flashAddr[4:0] == 5'h00) else $error("erase not row based");
  a_erase_stall: assert property (flashEraseEn |=> coreStall [*8]) else $error("core not stalled in erase");
  a_wr_stall: assert property (flashWrEn |-> coreStall) else $error("core not stalled in program");
  a_wr_step: assert property (flashWrEn && $past(flashWrEn) |-> flashAddr == $past(flashAddr) + 16'h0001)
    else $error("program address not stepping");
  a_wr_burst: assert property (wrBurstStart |-> ##31 wrBurstEnd) else $error("program burst not one block");
  a_no_mix: assert property (!(flashEraseEn && flashWrEn)) else $error("erase during program");
  a_bresp_time: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##3 s_axi_bvalid)
    else $error("write response late");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule // fsps_seq_assertions

// >>> tb/test_flash_self_program_sequencer.sv
/*
  Bench for the flash self-program sequencer over AXI4-Lite.
  Assumes the short erase and program counts set at dut.
*/
`timescale 1ns/1ps
`include "fsps_defines.vh"

module test_flash_self_program_sequencer;
  reg ref_clk = 1'b0;
  reg reset_n = 1'b0;
  reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  reg [31:0] s_axi_wdata = 32'h0;
  reg [3:0] s_axi_wstrb = 4'hF;
  reg s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire coreStall, flashEraseEn, flashWrEn;
  wire [15:0] flashAddr;
  wire [13:0] flashData;
  integer err_count = 0, n_checks = 0, wrCount = 0, erCount = 0, stallCount = 0, k, s0;
  reg [31:0] rv;
  reg [1:0] rr;

  fsps_sequencer #(.ERASE_CYCLES(32'd20), .PROG_CYCLES(32'd20)) dut (.ref_clk(ref_clk), .reset_n(reset_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .coreStall(coreStall), .flashEraseEn(flashEraseEn), .flashWrEn(flashWrEn), .flashAddr(flashAddr),
    .flashData(flashData));
  fsps_flash_model flash (.ref_clk(ref_clk), .flashEraseEn(flashEraseEn), .flashWrEn(flashWrEn),
    .flashAddr(flashAddr), .flashData(flashData));

  // ----------------------------------------
  // clock, counters, tasks
  // ----------------------------------------
  initial forever #2.5 ref_clk = ~ref_clk;

  // port activity tallies; write and erase compared as totals, stall as a difference
  always @(posedge ref_clk) begin
    if (flashWrEn === 1'b1) wrCount <= wrCount + 1;
    if (flashEraseEn === 1'b1) erCount <= erCount + 1;
    if (coreStall === 1'b1) stallCount <= stallCount + 1;
  end

  task chk(input [31:0] seen, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask

  // an edge passes first so back-to-back calls never drive twice per step
  task axi_wr(input [7:0] a, input [31:0] d, output [1:0] r);
    reg aw, w, done;
    begin
      @(posedge ref_clk);
      s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
      aw = 1; w = 1; done = 0;
      while (!done) begin
        @(posedge ref_clk);
        if (!aw && !w && s_axi_bvalid === 1'b1) begin r = s_axi_bresp; s_axi_bready <= 0; done = 1; end
        if (aw && s_axi_awready === 1'b1) begin aw = 0; s_axi_awvalid <= 0; end
        if (w && s_axi_wready === 1'b1) begin w = 0; s_axi_wvalid <= 0; end
      end
    end
  endtask

  task axi_rd(input [7:0] a, output [31:0] d, output [1:0] r);
    reg ar, done;
    begin
      @(posedge ref_clk);
      s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
      ar = 1; done = 0;
      while (!done) begin
        @(posedge ref_clk);
        if (!ar && s_axi_rvalid === 1'b1) begin d = s_axi_rdata; r = s_axi_rresp; s_axi_rready <= 0; done = 1; end
        if (ar && s_axi_arready === 1'b1) begin ar = 0; s_axi_arvalid <= 0; end
      end
    end
  endtask

  task wreg(input [7:0] a, input [7:0] d);
    begin
      axi_wr(a, {24'h0, d}, rr);
    end
  endtask

  task launch(input [7:0] k1, input [7:0] k2, input [7:0] ctl);
    begin
      wreg(`FSPS_OFF_UNLOCK, k1);
      wreg(`FSPS_OFF_UNLOCK, k2);
      wreg(`FSPS_OFF_CONTROL, ctl);
    end
  endtask

  // polls the launch bit, bounded by the watchdog
  task wait_idle;
    begin
      rv = 32'h1;
      while (rv[0] !== 1'b0) axi_rd(`FSPS_OFF_CONTROL, rv, rr);
    end
  endtask

  task stop_test;
    begin
      if (err_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge ref_clk);
    reset_n <= 1;
    axi_rd(8'h18, rv, rr);
    chk(rr, 2'h2);
    axi_rd(`FSPS_OFF_UNLOCK, rv, rr);
    chk(rv, 0);
    wreg(8'h18, 8'h00);
    chk(rr, 2'h2);
    // three latch-only loads into the row at 0x20
    wreg(`FSPS_OFF_ADDR_HIGH, 8'h00);
    chk(rr, 2'h0);
    wreg(`FSPS_OFF_DATA_HIGH, 8'h2A);
    wreg(`FSPS_OFF_CONTROL, 8'h8A);
    for (k = 0; k < 3; k = k + 1) begin
      wreg(`FSPS_OFF_ADDR_LOW, 8'h20 + k[7:0]);
      wreg(`FSPS_OFF_DATA_LOW, k[7:0]);
      launch(`FSPS_KEY_FIRST, `FSPS_KEY_SECOND, 8'h8B);
      wait_idle;
    end
    chk(wrCount, 0);
    // final latch with latch-only clear programs the whole block
    wreg(`FSPS_OFF_ADDR_LOW, 8'h23);
    wreg(`FSPS_OFF_DATA_LOW, 8'h77);
    wreg(`FSPS_OFF_CONTROL, 8'h82);
    launch(`FSPS_KEY_FIRST, `FSPS_KEY_SECOND, 8'h83);
    wait_idle;
    chk(wrCount, 32);
    for (k = 0; k < 32; k = k + 1) begin
      chk(flash.mem[32 + k], k < 3 ? {6'h2A, k[7:0]} : (k == 3 ? 14'h2A77 : 14'h3FFF));
    end
    // only latch 0 is loaded; the rest show the reset value
    wreg(`FSPS_OFF_ADDR_LOW, 8'h40);
    launch(`FSPS_KEY_FIRST, `FSPS_KEY_SECOND, 8'h83);
    wait_idle;
    chk(flash.mem[64], 14'h2A77);
    chk(flash.mem[65], 14'h3FFF);
    chk(flash.mem[95], 14'h3FFF);
    // wrong order, repeated key, program enable clear and config space set are all ignored
    launch(`FSPS_KEY_SECOND, `FSPS_KEY_FIRST, 8'h83);
    axi_rd(`FSPS_OFF_CONTROL, rv, rr);
    chk(rv[0], 0);
    launch(`FSPS_KEY_FIRST, `FSPS_KEY_FIRST, 8'h83);
    axi_rd(`FSPS_OFF_CONTROL, rv, rr);
    chk(rv[0], 0);
    launch(`FSPS_KEY_FIRST, `FSPS_KEY_SECOND, 8'h81);
    axi_rd(`FSPS_OFF_CONTROL, rv, rr);
    chk(rv[0], 0);
    launch(`FSPS_KEY_FIRST, `FSPS_KEY_SECOND, 8'hC3);
    axi_rd(`FSPS_OFF_CONTROL, rv, rr);
    chk(rv[0], 0);
    chk(wrCount + erCount, 64);
    // row erase from a mid-row address, polled on the erase bit
    wreg(`FSPS_OFF_ADDR_LOW, 8'h25);
    wreg(`FSPS_OFF_CONTROL, 8'h86);
    s0 = stallCount;
    launch(`FSPS_KEY_FIRST, `FSPS_KEY_SECOND, 8'h87);
    axi_rd(`FSPS_OFF_CONTROL, rv, rr);
    chk(rv[2], 1);
    while (rv[2] !== 1'b0) axi_rd(`FSPS_OFF_CONTROL, rv, rr);
    chk(stallCount - s0, 20);
    chk(erCount, 1);
    chk(flash.mem[35], 14'h3FFF);
    chk(flash.mem[31], 14'h0000);
    stop_test;
  end

  // whole run needs a few hundred cycles
  initial begin
    #100000;
    err_count = err_count + 1;
    stop_test;
  end
endmodule // test_flash_self_program_sequencer

bind fsps_sequencer fsps_seq_assertions chk_i (.ref_clk(ref_clk), .reset_n(reset_n),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .coreStall(coreStall),
  .flashEraseEn(flashEraseEn), .flashWrEn(flashWrEn), .flashAddr(flashAddr));
